// file: addr_decode_consts.svh
`ifndef ADDR_DECODE_CONSTS_SVH
`define ADDR_DECODE_CONSTS_SVH

// ----------------------------------------
// address space
// ----------------------------------------
`define ADDR_W 24
`define BANK_W 8
`define OFS_W 16
`define BANK_ZERO 8'h00
`define ADDR_TOP 24'hFFFFFF

// ----------------------------------------
// bank zero areas
// ----------------------------------------
`define SFR_LO 16'h0000
`define SFR_HI 16'h007F
`define RAM_LO 16'h0080
`define RAM_HI 16'h087F
`define RAM_BYTES 2048
`define RAM_IDX_W 11
`define VEC_LO 16'hFFD6
`define VEC_HI 16'hFFFF

// ----------------------------------------
// single register locations
// ----------------------------------------
`define PULSE_DATA1_OFS 16'h001C
`define PULSE_DATA0_OFS 16'h001D
`define PROC_MODE0_OFS 16'h005E
`define PROC_MODE1_OFS 16'h005F
`define WDOG_CNT_OFS 16'h0060
`define WDOG_FSEL_OFS 16'h0061
`define WAVE_MODE_OFS 16'h0062
`define RESERVED_OFS 16'h0063

// ----------------------------------------
// direct page
// ----------------------------------------
`define DP_OFS_W 8
`define DP_BASE_RST 16'h0000

`endif

// file: addr_decode_pkg.sv
package addr_decode_pkg;
  typedef enum logic [3:0] {
    TGT_SFR = 4'h1,
    TGT_RAM = 4'h2,
    TGT_VEC = 4'h4,
    TGT_EXT = 4'h8
  } target_t;

  typedef struct packed {
    logic pulse_data1;
    logic pulse_data0;
    logic proc_mode0;
    logic proc_mode1;
    logic wdog_cnt;
    logic wdog_fsel;
    logic wave_mode;
  } reg_sel_t;

  typedef struct packed {
    logic valid;
    target_t target;
    reg_sel_t regs;
    logic [6:0] sfr_idx;
    logic [10:0] ram_idx;
    logic [23:0] addr;
  } decode_t;

  typedef struct packed {
    logic [15:0] dp_base;
    decode_t dec;
  } decode_state_t;
endpackage : addr_decode_pkg

// file: addr_decoder.sv
`timescale 1ns/1ns
`include "addr_decode_consts.svh"

// Behaviour
// (RL1) accept a 24-bit address spanning 000000 to FFFFFF
// (RL2) upper eight bits are the bank number, 64 Kbyte banks 00 to FF
// (RL3) on-chip RAM and peripheral registers live in bank zero only
// (RL4) bank zero FFD6 to FFFF is the reset and interrupt vector area
// (RL5) bank zero 80 to 87F selects the 2048-byte internal RAM
// (RL6) bank zero 00 to 7F selects the peripheral control registers
// (RL7) direct page address is programmable base plus 8-bit offset in bank zero
// (RL8) pulse output data register one selected at 1C
// (RL9) pulse output data register zero selected at 1D
// (RL10) processor mode registers zero and one at 5E and 5F
// (RL11) watchdog counter at 60, watchdog frequency select at 61
// (RL12) waveform mode register at 62; 63 reserved, selects nothing
// (RL13) anything not internal RAM or peripheral registers goes external; the decoder gives bank zero FFD6 to FFFF TGT_VEC instead of TGT_EXT
module addr_decoder
  import addr_decode_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic dp_mode_i,
  input wire logic [`DP_OFS_W-1:0] dp_ofs_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic dp_base_we_i,
  input wire logic [`OFS_W-1:0] dp_base_i,
  output logic valid_o,
  output target_t target_o,
  output reg_sel_t reg_sel_o,
  output logic [6:0] sfr_idx_o,
  output logic [`RAM_IDX_W-1:0] ram_idx_o,
  output logic [`ADDR_W-1:0] addr_o,
  output logic [`OFS_W-1:0] dp_base_o
);

  decode_state_t state_ff;
  decode_state_t nxt_state;
  logic [`ADDR_W-1:0] eff_addr;
  logic [`BANK_W-1:0] bank;
  logic [`OFS_W-1:0] ofs;
  logic in_bank0;

  // ----------------------------------------
  // effective address
  // ----------------------------------------
  always_comb begin
    // (RL7) direct page forming
    if (dp_mode_i) begin
      eff_addr = {`BANK_ZERO, 16'(state_ff.dp_base + {8'h00, dp_ofs_i})};
    end else begin
      eff_addr = addr_i;
    end
  end

  // (RL1) bank and offset split
  assign bank = eff_addr[`ADDR_W-1:`OFS_W];
  assign ofs = eff_addr[`OFS_W-1:0];
  // (RL2) bank zero test
  assign in_bank0 = (bank == `BANK_ZERO);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.dec.valid = req_i;
    nxt_state.dec.addr = eff_addr;
    nxt_state.dec.regs = '0;
    nxt_state.dec.sfr_idx = 7'h00;
    nxt_state.dec.ram_idx = 11'h000;
    nxt_state.dec.target = TGT_EXT;
    if (dp_base_we_i) begin
      nxt_state.dp_base = dp_base_i;
    end
    if (req_i) begin
      // (RL3) internal areas bank zero only
      if (in_bank0 && ofs <= `SFR_HI) begin
        // (RL6) peripheral area
        nxt_state.dec.target = TGT_SFR;
        nxt_state.dec.sfr_idx = ofs[6:0];
        // (RL8) pulse data one
        nxt_state.dec.regs.pulse_data1 = (ofs == `PULSE_DATA1_OFS);
        // (RL9) pulse data zero
        nxt_state.dec.regs.pulse_data0 = (ofs == `PULSE_DATA0_OFS);
        // (RL10) processor mode selects
        nxt_state.dec.regs.proc_mode0 = (ofs == `PROC_MODE0_OFS);
        nxt_state.dec.regs.proc_mode1 = (ofs == `PROC_MODE1_OFS);
        // (RL11) watchdog selects
        nxt_state.dec.regs.wdog_cnt = (ofs == `WDOG_CNT_OFS);
        nxt_state.dec.regs.wdog_fsel = (ofs == `WDOG_FSEL_OFS);
        // (RL12) waveform mode, reserved gets nothing
        nxt_state.dec.regs.wave_mode = (ofs == `WAVE_MODE_OFS);
      end else if (in_bank0 && ofs >= `RAM_LO && ofs <= `RAM_HI) begin
        // (RL5) internal ram
        nxt_state.dec.target = TGT_RAM;
        nxt_state.dec.ram_idx = 11'(ofs - `RAM_LO);
      end else if (in_bank0 && ofs >= `VEC_LO) begin
        // (RL4) vector area, backed externally
        nxt_state.dec.target = TGT_VEC;
      end else begin
        // (RL13) external access
        nxt_state.dec.target = TGT_EXT;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_ff <= '{dp_base: `DP_BASE_RST,
                    dec: '{valid: 1'b0, target: TGT_EXT, regs: '0,
                           sfr_idx: 7'h00, ram_idx: 11'h000, addr: 24'h000000}};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign valid_o = state_ff.dec.valid;
  assign target_o = state_ff.dec.target;
  assign reg_sel_o = state_ff.dec.regs;
  assign sfr_idx_o = state_ff.dec.sfr_idx;
  assign ram_idx_o = state_ff.dec.ram_idx;
  assign addr_o = state_ff.dec.addr;
  assign dp_base_o = state_ff.dp_base;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_req_bank0(logic [15:0] lo, logic [15:0] hi);
    req_i && in_bank0 && ofs >= lo && ofs <= hi;
  endsequence

  // page access held over two edges
  sequence s_dp_steady;
    dp_mode_i && !dp_base_we_i ##1 dp_mode_i;
  endsequence

  a_sfr_route: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL6
    s_req_bank0(`SFR_LO, `SFR_HI) |=> target_o == TGT_SFR && valid_o)
    else $error("peripheral address not routed to registers");
  a_ram_route: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL5
    s_req_bank0(`RAM_LO, `RAM_HI) |=> target_o == TGT_RAM
      && ram_idx_o == 11'($past(ofs) - `RAM_LO))
    else $error("ram address not routed to ram");
  a_vec_route: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL4
    s_req_bank0(`VEC_LO, `VEC_HI) |=> target_o == TGT_VEC)
    else $error("vector address misrouted");
  a_bank_only: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL3
    req_i && !in_bank0 |=> target_o == TGT_EXT)
    else $error("non-zero bank routed internally");
  a_ext_route: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL13
    req_i && in_bank0 && ofs > `RAM_HI && ofs < `VEC_LO |=> target_o == TGT_EXT)
    else $error("unclaimed address not external");
  a_addr_pass: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1
    !dp_mode_i |=> addr_o == $past(addr_i))
    else $error("address not carried through");
  a_bank_field: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2
    valid_o && target_o != TGT_EXT |-> addr_o[23:16] == `BANK_ZERO)
    else $error("internal target outside bank zero");
  a_dp_form: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL7
    s_dp_steady |=>
      addr_o == {`BANK_ZERO, 16'($past(dp_base_o) + {8'h00, $past(dp_ofs_i)})})
    else $error("direct page address wrong");
  a_pulse_one: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL8
    req_i && eff_addr == {`BANK_ZERO, `PULSE_DATA1_OFS} |=> reg_sel_o.pulse_data1)
    else $error("pulse data one not selected");
  a_pulse_zero: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL9
    reg_sel_o.pulse_data0 |-> addr_o == {`BANK_ZERO, `PULSE_DATA0_OFS} && valid_o)
    else $error("pulse data zero select wrong");
  a_proc_mode: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL10
    reg_sel_o.proc_mode0 || reg_sel_o.proc_mode1 |-> addr_o[15:1] == 15'h002F)
    else $error("processor mode select wrong");
  a_wdog_sel: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL11
    req_i && eff_addr == {`BANK_ZERO, `WDOG_FSEL_OFS} |=> reg_sel_o.wdog_fsel
      && !reg_sel_o.wdog_cnt)
    else $error("watchdog select wrong");
  a_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL12
    req_i && eff_addr == {`BANK_ZERO, `RESERVED_OFS} |=> reg_sel_o == '0)
    else $error("reserved location selected");

  // ----------------------------------------
  // select checks
  // ----------------------------------------
  a_pulse_one_only: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL8
    reg_sel_o.pulse_data1 |-> addr_o == {`BANK_ZERO, `PULSE_DATA1_OFS} && valid_o)
    else $error("pulse data one select wrong");
  a_pulse_zero_in: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL9
    req_i && eff_addr == {`BANK_ZERO, `PULSE_DATA0_OFS} |=> reg_sel_o.pulse_data0)
    else $error("pulse data zero not selected");
  a_mode_zero: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL10
    req_i && eff_addr == {`BANK_ZERO, `PROC_MODE0_OFS} |=> reg_sel_o.proc_mode0)
    else $error("processor mode zero not selected");
  a_mode_one: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL10
    req_i && eff_addr == {`BANK_ZERO, `PROC_MODE1_OFS} |=> reg_sel_o.proc_mode1)
    else $error("processor mode one not selected");
  a_wdog_count: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL11
    req_i && eff_addr == {`BANK_ZERO, `WDOG_CNT_OFS} |=> reg_sel_o.wdog_cnt)
    else $error("watchdog counter not selected");
  a_wave_sel: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL12
    req_i && eff_addr == {`BANK_ZERO, `WAVE_MODE_OFS} |=> reg_sel_o.wave_mode)
    else $error("waveform mode not selected");
  a_one_select: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL12
    $onehot0(reg_sel_o))
    else $error("more than one register select");

  // ----------------------------------------
  // state checks
  // ----------------------------------------
  a_sfr_index: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL6
    s_req_bank0(`SFR_LO, `SFR_HI) |=> sfr_idx_o == $past(ofs[6:0]))
    else $error("peripheral index wrong");
  a_valid_follow: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1
    req_i |=> valid_o)
    else $error("request not answered");
  a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL13
    !req_i |=> !valid_o && target_o == TGT_EXT && reg_sel_o == '0)
    else $error("idle cycle not quiet");
  a_target_onehot: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2
    $onehot(target_o))
    else $error("target not one-hot");
  a_base_load: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL7
    dp_base_we_i |=> dp_base_o == $past(dp_base_i))
    else $error("direct page base not loaded");
  a_base_hold: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL7
    !dp_base_we_i |=> $stable(dp_base_o))
    else $error("direct page base changed unasked");
  a_reset_state: assert property (@(posedge core_clk_i) // RL7
    rst_i |=> !valid_o && target_o == TGT_EXT && dp_base_o == `DP_BASE_RST)
    else $error("reset state wrong");

endmodule : addr_decoder

// file: core_model.sv
`timescale 1ns/1ns
// ------------------------------
// processor core issuing accesses
// ------------------------------
module core_model (
  input wire logic core_clk_i,
  output logic req_o,
  output logic dp_mode_o,
  output logic [7:0] dp_ofs_o,
  output logic [23:0] addr_o,
  output logic base_we_o,
  output logic [15:0] base_o
);
  initial begin
    {req_o, dp_mode_o, dp_ofs_o, addr_o, base_we_o, base_o} = '0;
  end
  task access(input logic m, input logic [7:0] o, input logic [23:0] a);
    @(negedge core_clk_i);
    {req_o, dp_mode_o, dp_ofs_o, addr_o} = {1'b1, m, o, a};
    @(negedge core_clk_i);
    // released lines show the inverse
    {req_o, dp_ofs_o, addr_o} = {1'b0, ~o, ~a};
  endtask : access
  task set_base(input logic [15:0] b);
    @(negedge core_clk_i);
    {base_we_o, base_o} = {1'b1, b};
    @(negedge core_clk_i);
    {base_we_o, base_o} = {1'b0, ~b};
  endtask : set_base
endmodule : core_model

// file: memory_map_address_decoder_bench.sv
`timescale 1ns/1ns
module memory_map_address_decoder_bench;
  import addr_decode_pkg::*;
  logic core_clk_i, rst_i, req, dp_mode, base_we, valid;
  logic [7:0] dp_ofs;
  logic [23:0] addr, eff_addr;
  logic [15:0] base, dp_base;
  target_t target;
  reg_sel_t reg_sel;
  logic [6:0] sfr_idx;
  logic [10:0] ram_idx;
  int errors = 0;
  int checked = 0;
  initial begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  core_model core_model_i (.core_clk_i(core_clk_i), .req_o(req), .dp_mode_o(dp_mode),
    .dp_ofs_o(dp_ofs), .addr_o(addr), .base_we_o(base_we), .base_o(base));
  addr_decoder addr_decoder_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req),
    .dp_mode_i(dp_mode), .dp_ofs_i(dp_ofs), .addr_i(addr), .dp_base_we_i(base_we),
    .dp_base_i(base), .valid_o(valid), .target_o(target), .reg_sel_o(reg_sel),
    .sfr_idx_o(sfr_idx), .ram_idx_o(ram_idx), .addr_o(eff_addr), .dp_base_o(dp_base));
  // ------------------------------
  // checking
  // ------------------------------
  task check(input string n, input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  task judge(input logic [23:0] a);
    logic [15:0] ofs [7];
    logic [3:0] t;
    logic [6:0] s;
    ofs = '{16'h001C, 16'h001D, 16'h005E, 16'h005F, 16'h0060, 16'h0061, 16'h0062};
    t = a[23:16] != 8'h00 ? 4'h8 : a[15:0] <= 16'h007F ? 4'h1 :
        a[15:0] <= 16'h087F ? 4'h2 : a[15:0] >= 16'hFFD6 ? 4'h4 : 4'h8;
    for (int i = 0; i < 7; i++) s[6-i] = a == {8'h00, ofs[i]};
    check("valid", {23'h0, valid}, 24'h1);
    check("addr", eff_addr, a);
    check("target", {20'h0, target}, {20'h0, t});
    check("sfr_idx", {17'h0, sfr_idx}, t == 4'h1 ? {17'h0, a[6:0]} : 24'h0);
    check("ram_idx", {13'h0, ram_idx}, t == 4'h2 ? {8'h0, a[15:0] - 16'h0080} : 24'h0);
    check("reg_sel", {17'h0, reg_sel}, {17'h0, s});
  endtask : judge
  task print_verdict;
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // ------------------------------
  // scenarios
  // ------------------------------
  task test_regions;
    logic [23:0] tab [12];
    tab = '{24'h000000, 24'h00007F, 24'h000080, 24'h00087F, 24'h000880, 24'h00FFD5,
            24'h00FFD6, 24'h00FFFF, 24'h010000, 24'h01001C, 24'hFF0080, 24'hFFFFFF};
    foreach (tab[i]) begin
      core_model_i.access(1'b0, 8'h00, tab[i]);
      judge(tab[i]);
    end
  endtask : test_regions
  task test_selects;
    for (int a = 24'h1B; a <= 24'h63; a++) begin
      core_model_i.access(1'b0, 8'h00, a[23:0]);
      judge(a[23:0]);
    end
  endtask : test_selects
  task test_dpage;
    core_model_i.set_base(16'h0100);
    core_model_i.access(1'b1, 8'h05, 24'hFFFFFF);
    judge(24'h000105);
    core_model_i.set_base(16'hFF80);
    check("dp_base", {8'h0, dp_base}, 24'h00FF80);
    core_model_i.access(1'b1, 8'h90, 24'h010000);
    judge(24'h000010);
  endtask : test_dpage
  task test_reset;
    core_model_i.set_base(16'h0200);
    check("dp_base load", {8'h0, dp_base}, 24'h000200);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check("mid rst dp_base", {8'h0, dp_base}, 24'h0);
    check("mid rst valid", {23'h0, valid}, 24'h0);
    rst_i = 1'b0;
  endtask : test_reset
  task test_idle;
    core_model_i.access(1'b0, 8'h00, 24'h00001C);
    @(negedge core_clk_i);
    check("idle valid", {23'h0, valid}, 24'h0);
    check("idle target", {20'h0, target}, 24'h8);
    check("idle reg_sel", {17'h0, reg_sel}, 24'h0);
  endtask : test_idle
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    rst_i = 1;
    repeat (8) @(negedge core_clk_i);
    check("rst valid", {23'h0, valid}, 24'h0);
    check("rst dp_base", {8'h0, dp_base}, 24'h0);
    rst_i = 0;
    test_regions();
    test_selects();
    test_dpage();
    test_reset();
    test_idle();
    print_verdict();
  end
endmodule : memory_map_address_decoder_bench
